// ==== eea_pkg.sv ====
// Constants shared by the EEPROM access controller files
package eea_pkg;

    // Register addresses in I/O space
    localparam logic [5:0] EEA_ADDR_CONTROL = 6'h1c;
    localparam logic [5:0] EEA_ADDR_DATA    = 6'h1d;
    localparam logic [5:0] EEA_ADDR_ADDRESS = 6'h1e;

    // Control register fields
    localparam int EEA_BIT_READ_STROBE  = 0;
    localparam int EEA_BIT_WRITE_STROBE = 1;
    localparam int EEA_BIT_WRITE_ARM    = 2;
    localparam int EEA_BIT_IRQ_ENABLE   = 3;

    // Reset values
    localparam logic [7:0] EEA_RESET_DATA    = 8'h00;
    localparam logic [7:0] EEA_RESET_ADDRESS = 8'h00;
    localparam logic [7:0] EEA_ZERO_BYTE     = 8'h00;

    // Memory geometry
    localparam int EEA_DEPTH = 256;
    localparam int EEA_AW    = 8;
    localparam int EEA_DW    = 8;

    // Timing
    localparam int EEA_CLK_MHZ        = 50;
    localparam int EEA_WRITE_TIME_US  = 4000;
    localparam int EEA_WRITE_CYCLES   = EEA_WRITE_TIME_US * EEA_CLK_MHZ;
    localparam int EEA_ARM_CYCLES     = 4;
    localparam int EEA_STALL_WRITE    = 2;
    localparam int EEA_STALL_READ     = 4;

    // Programming engine states
    typedef enum logic [0:0] {
        EEA_IDLE,
        EEA_PROG
    } eea_state_t;

endpackage

// ==== eea_mem.sv ====
// Byte-wide data memory with registered read port
`timescale 1ns/1ps
module eea_mem #(
    parameter int DEPTH = 256,
    parameter int AW    = 8,
    parameter int DW    = 8
) (
    // Clock
    input  wire logic          clk_i,
    // Access
    input  wire logic [AW-1:0] addr_i,
    input  wire logic          we_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem_q [DEPTH];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[addr_i] <= wdata_i;
        end
        rdata_o <= mem_q[addr_i];
    end

endmodule

// ==== eea_ctrl.sv ====
// EEPROM access controller: address, data and control registers
`timescale 1ns/1ps
module eea_ctrl #(
    parameter int WRITE_CYCLES = eea_pkg::EEA_WRITE_CYCLES
) (
    // Clock and resets
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       power_on_reset_n_i,
    // CPU I/O register port
    input  wire logic [5:0] io_addr_i,
    input  wire logic       io_wr_i,
    input  wire logic       io_rd_i,
    input  wire logic [7:0] io_wdata_i,
    output logic      [7:0] io_rdata_o,
    // CPU core status and control
    input  wire logic       global_irq_enable_i,
    output logic            cpu_stall_o,
    output logic            ready_irq_o
);

    localparam int WCW = $clog2(WRITE_CYCLES + 1);
    localparam logic [WCW-1:0] WRITE_LAST = WCW'(WRITE_CYCLES - 1);
    localparam logic [2:0] ARM_LOAD   = 3'(eea_pkg::EEA_ARM_CYCLES);
    localparam logic [2:0] STALL_WR   = 3'(eea_pkg::EEA_STALL_WRITE);
    localparam logic [2:0] STALL_RD   = 3'(eea_pkg::EEA_STALL_READ);

    // Reset synchronisers
    logic rst_meta_q;
    logic rst_n_q;
    logic por_meta_q;
    logic por_n_q;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    always_ff @(posedge clk_i or negedge power_on_reset_n_i) begin
        if (!power_on_reset_n_i) begin
            por_meta_q <= 1'b0;
            por_n_q    <= 1'b0;
        end else begin
            por_meta_q <= 1'b1;
            por_n_q    <= por_meta_q;
        end
    end

    // Register state
    logic [7:0]            address_q;
    logic [7:0]            data_q;
    logic                  irq_enable_q;
    logic                  arm_q;
    logic [2:0]            arm_cnt_q;
    logic                  read_q;
    logic                  read_pend_q;
    logic [2:0]            stall_cnt_q;
    logic [7:0]            rdata_q;
    eea_pkg::eea_state_t   state_q;
    logic [WCW-1:0]        wcnt_q;
    logic [7:0]            prog_addr_q;
    logic [7:0]            prog_data_q;

    // Decode
    wire wr_ctrl     = io_wr_i && (io_addr_i == eea_pkg::EEA_ADDR_CONTROL);
    wire wr_data     = io_wr_i && (io_addr_i == eea_pkg::EEA_ADDR_DATA);
    wire wr_address  = io_wr_i && (io_addr_i == eea_pkg::EEA_ADDR_ADDRESS);
    wire busy        = (state_q == eea_pkg::EEA_PROG);
    // Cell port follows the byte under programming while busy
    wire [7:0] mem_addr = busy ? prog_addr_q : address_q;
    wire set_arm     = wr_ctrl && io_wdata_i[eea_pkg::EEA_BIT_WRITE_ARM];
    wire set_read    = wr_ctrl && io_wdata_i[eea_pkg::EEA_BIT_READ_STROBE];
    // Strobe honoured only if armed by an earlier write still inside its window and not already busy
    wire start_write = wr_ctrl && io_wdata_i[eea_pkg::EEA_BIT_WRITE_STROBE]
                       && arm_q && !busy;
    wire prog_done   = busy && (wcnt_q == WRITE_LAST);
    wire mem_we      = prog_done;
    wire [7:0] mem_rdata;

    // Control register image, upper nibble forced to zero
    wire [7:0] ctrl_image = {4'h0, irq_enable_q, arm_q, busy, read_q};

    // Read mux
    wire [7:0] rd_mux = (io_addr_i == eea_pkg::EEA_ADDR_CONTROL) ? ctrl_image :
                        (io_addr_i == eea_pkg::EEA_ADDR_DATA)    ? data_q     :
                        (io_addr_i == eea_pkg::EEA_ADDR_ADDRESS) ? address_q  :
                        eea_pkg::EEA_ZERO_BYTE;

    // Address, data and interrupt enable registers
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            address_q    <= eea_pkg::EEA_RESET_ADDRESS;
            data_q       <= eea_pkg::EEA_RESET_DATA;
            irq_enable_q <= 1'b0;
        end else begin
            // Writes during programming go straight through to the cell
            if (wr_address) begin
                address_q <= io_wdata_i;
            end
            if (read_pend_q) begin
                data_q <= mem_rdata;
            end else if (wr_data) begin
                data_q <= io_wdata_i;
            end
            if (wr_ctrl) begin
                irq_enable_q <= io_wdata_i[eea_pkg::EEA_BIT_IRQ_ENABLE];
            end
        end
    end

    // Arming window
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            arm_q     <= 1'b0;
            arm_cnt_q <= 3'd0;
        end else if (set_arm) begin
            arm_q     <= 1'b1;
            arm_cnt_q <= ARM_LOAD;
        end else if (arm_cnt_q > 3'd1) begin
            arm_cnt_q <= arm_cnt_q - 3'd1;
        end else begin
            arm_q     <= 1'b0;
            arm_cnt_q <= 3'd0;
        end
    end

    // Read strobe: memory address presented this cycle, data next
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            read_q      <= 1'b0;
            read_pend_q <= 1'b0;
        end else begin
            read_pend_q <= set_read && !start_write;
            if (set_read && !start_write) begin
                read_q <= 1'b1;
            end else if (read_pend_q) begin
                read_q <= 1'b0;
            end
        end
    end

    // CPU stall counter
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stall_cnt_q <= 3'd0;
        end else if (start_write) begin
            stall_cnt_q <= STALL_WR;
        end else if (set_read) begin
            stall_cnt_q <= STALL_RD;
        end else if (stall_cnt_q != 3'd0) begin
            stall_cnt_q <= stall_cnt_q - 3'd1;
        end
    end

    // Programming engine survives the system reset, only power-on clears it
    always_ff @(posedge clk_i or negedge por_n_q) begin
        if (!por_n_q) begin
            state_q <= eea_pkg::EEA_IDLE;
            wcnt_q  <= '0;
        end else begin
            unique case (state_q)
                eea_pkg::EEA_IDLE: begin
                    wcnt_q <= '0;
                    if (start_write && rst_n_q) begin
                        state_q <= eea_pkg::EEA_PROG;
                    end
                end
                eea_pkg::EEA_PROG: begin
                    if (prog_done) begin
                        state_q <= eea_pkg::EEA_IDLE;
                    end else begin
                        wcnt_q <= wcnt_q + WCW'(1);
                    end
                end
            endcase
        end
    end

    // Byte under programming, captured at the strobe so that a system reset
    // cannot redirect it; register writes while busy still disturb it
    always_ff @(posedge clk_i or negedge por_n_q) begin
        if (!por_n_q) begin
            prog_addr_q <= eea_pkg::EEA_RESET_ADDRESS;
            prog_data_q <= eea_pkg::EEA_RESET_DATA;
        end else if (start_write) begin
            prog_addr_q <= address_q;
            prog_data_q <= data_q;
        end else if (busy) begin
            if (wr_address) begin
                prog_addr_q <= io_wdata_i;
            end
            if (wr_data) begin
                prog_data_q <= io_wdata_i;
            end
        end
    end

    // Read data register
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= eea_pkg::EEA_ZERO_BYTE;
        end else if (io_rd_i) begin
            rdata_q <= rd_mux;
        end
    end

    eea_mem #(
        .DEPTH (eea_pkg::EEA_DEPTH),
        .AW    (eea_pkg::EEA_AW),
        .DW    (eea_pkg::EEA_DW)
    ) u_mem (
        .clk_i   (clk_i),
        .addr_i  (mem_addr),
        .we_i    (mem_we),
        .wdata_i (prog_data_q),
        .rdata_o (mem_rdata)
    );

    assign io_rdata_o  = rdata_q;
    assign cpu_stall_o = (stall_cnt_q != 3'd0);
    // Level request, held while idle; the core acknowledges by masking
    assign ready_irq_o = irq_enable_q && global_irq_enable_i && !busy;

endmodule

// ==== eea_ctrl_chk.sv ====
// Port-level assertions for the EEPROM access controller
`timescale 1ns/1ps
module eea_ctrl_chk (
    // Clock and resets
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    input  wire logic       power_on_reset_n_i,
    // CPU side
    input  wire logic [5:0] io_addr_i,
    input  wire logic       io_wr_i,
    input  wire logic       io_rd_i,
    input  wire logic [7:0] io_wdata_i,
    input  wire logic [7:0] io_rdata_o,
    input  wire logic       global_irq_enable_i,
    input  wire logic       cpu_stall_o,
    input  wire logic       ready_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    wire c_wr  = io_wr_i && io_addr_i == eea_pkg::EEA_ADDR_CONTROL;
    wire c_rd  = io_rd_i && io_addr_i == eea_pkg::EEA_ADDR_CONTROL;
    wire arm_w = c_wr && io_wdata_i[2:1] == 2'b10;
    wire unmap = io_rd_i && (io_addr_i < 6'h1c || io_addr_i > 6'h1e);
    a_read_stall: assert property (c_wr && io_wdata_i[1:0] == 2'b01 |=>
        cpu_stall_o [*4] ##1 !cpu_stall_o) else $error("read stall length wrong");
    a_write_stall: assert property (arm_w ##[1:3] (c_wr && io_wdata_i[2:1] == 2'b01) |=>
        cpu_stall_o [*2] ##1 !cpu_stall_o) else $error("write stall length wrong");
    a_ctrl_upper: assert property (c_rd |=> io_rdata_o[7:4] == 4'h0)
        else $error("control upper bits not zero");
    a_unmapped_zero: assert property (unmap |=> io_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_irq_global: assert property (!global_irq_enable_i |-> !ready_irq_o)
        else $error("ready irq without global enable");
    a_irq_idle: assert property (ready_irq_o && c_rd |=> io_rdata_o[3:1] == 3'b100
        || io_rdata_o[3:1] == 3'b110) else $error("ready irq while busy or disabled");
    a_arm_hold: assert property (arm_w ##[1:3] c_rd |=> io_rdata_o[2])
        else $error("arm bit lost inside window");
    a_arm_clear: assert property (arm_w ##1 (!io_wr_i) [*4] ##[1:3] c_rd |=>
        !io_rdata_o[2]) else $error("arm bit not cleared after window");
endmodule

bind eea_ctrl eea_ctrl_chk chk (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .power_on_reset_n_i(power_on_reset_n_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .global_irq_enable_i(global_irq_enable_i), .cpu_stall_o(cpu_stall_o),
    .ready_irq_o(ready_irq_o));

// ==== eea_cpu.sv ====
// CPU core model issuing I/O register accesses
`timescale 1ns/1ps
module eea_cpu (
    input  wire logic       clk_i,
    input  wire logic [7:0] io_rdata_i,
    output logic      [5:0] io_addr_o,
    output logic            io_wr_o,
    output logic            io_rd_o,
    output logic      [7:0] io_wdata_o
);
    initial begin
        io_addr_o  = 6'h00;
        io_wr_o    = 1'b0;
        io_rd_o    = 1'b0;
        io_wdata_o = 8'h00;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk_i);
        io_addr_o  = a;
        io_wdata_o = d;
        io_wr_o    = 1'b1;
        @(negedge clk_i);
        io_wr_o    = 1'b0;
        io_wdata_o = ~d; // Stale data must not look valid
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk_i);
        io_addr_o = a;
        io_rd_o   = 1'b1;
        @(negedge clk_i);
        d         = io_rdata_i;
        io_rd_o   = 1'b0;
    endtask
    // Arm with strobe zero, then strobe inside the window
    task automatic prog(input logic [7:0] ie);
        wr(eea_pkg::EEA_ADDR_CONTROL, ie | 8'h04);
        wr(eea_pkg::EEA_ADDR_CONTROL, ie | 8'h02);
    endtask
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the EEPROM access controller
`timescale 1ns/1ps
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, s); end end
module tb_top;
    localparam logic [5:0] CT = eea_pkg::EEA_ADDR_CONTROL;
    localparam logic [5:0] DT = eea_pkg::EEA_ADDR_DATA;
    localparam logic [5:0] AD = eea_pkg::EEA_ADDR_ADDRESS;
    logic       clk_i;
    logic       reset_n, por_n, glob, stall, irq, io_wr, io_rd;
    logic [5:0] io_addr;
    logic [7:0] io_wdata, io_rdata, v;
    int         n_errors = 0;
    int         num_checks = 0;
    int         mem [256];
    int         a, d;
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    eea_ctrl #(.WRITE_CYCLES(20)) dut (.clk_i(clk_i), .reset_n_i(reset_n),
        .power_on_reset_n_i(por_n), .io_addr_i(io_addr), .io_wr_i(io_wr), .io_rd_i(io_rd),
        .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .global_irq_enable_i(glob),
        .cpu_stall_o(stall), .ready_irq_o(irq));
    eea_cpu cpu (.clk_i(clk_i), .io_rdata_i(io_rdata), .io_addr_o(io_addr), .io_wr_o(io_wr),
        .io_rd_o(io_rd), .io_wdata_o(io_wdata));
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_idle; // Bounded poll of the busy bit
        int k;
        k = 0;
        v = 8'h02;
        while (v[1] && k < 100) begin
            cpu.rd(CT, v);
            k++;
        end
        if (v[1]) begin
            n_errors++;
            test_done();
        end
    endtask
    task automatic wr_byte(int ad, int dt, logic [7:0] ie);
        glob = 1'b0; // Window kept free of interrupts
        cpu.wr(AD, 8'(ad));
        cpu.wr(DT, 8'(dt));
        cpu.prog(ie);
        mem[ad] = dt;
        glob = 1'b1;
        cpu.rd(CT, v);
        // Arm bit is still visible when sampled at its fourth edge
        `CHK("busy", 8'h06 | ie, v)
        `CHK("irq busy", 1'b0, irq)
        wait_idle();
        `CHK("irq idle", ie[3], irq)
    endtask
    task automatic rd_byte(int ad);
        wait_idle();
        cpu.wr(AD, 8'(ad));
        cpu.wr(CT, 8'h01);
        cpu.rd(DT, v);
        `CHK("data", 8'(mem[ad]), v)
        cpu.rd(CT, v);
        `CHK("ctrl", 8'h00, v)
    endtask
    initial begin
        reset_n = 1'b0;
        por_n   = 1'b0;
        glob    = 1'b0;
        void'($urandom(85643));
        repeat (16) @(negedge clk_i);
        reset_n = 1'b1;
        por_n   = 1'b1;
        repeat (3) @(negedge clk_i);
        cpu.rd(CT, v);
        `CHK("ctrl reset", 8'h00, v)
        cpu.rd(DT, v);
        `CHK("data reset", 8'h00, v)
        cpu.rd(6'h1f, v);
        `CHK("unmapped", 8'h00, v)
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 0 : (i == 1) ? 255 : int'($urandom_range(254, 1));
            d = int'($urandom_range(255, 0));
            wr_byte(a, d, i[0] ? 8'h08 : 8'h00);
            rd_byte(a);
        end
        // Strobe alone, strobe with arm, and strobe after expiry: all ignored
        glob = 1'b0;
        cpu.wr(DT, ~8'(mem[a]));
        cpu.wr(CT, 8'h02);
        cpu.rd(CT, v);
        `CHK("no arm", 8'h00, v)
        cpu.wr(CT, 8'h06);
        cpu.rd(CT, v);
        `CHK("same write", 8'h04, v)
        cpu.wr(CT, 8'h04);
        cpu.rd(CT, v);
        `CHK("armed", 8'h04, v)
        repeat (3) @(negedge clk_i);
        cpu.rd(CT, v);
        `CHK("expired", 8'h00, v)
        cpu.wr(CT, 8'h02);
        cpu.rd(CT, v);
        `CHK("late strobe", 8'h00, v)
        rd_byte(a);
        // Programming survives a system reset
        cpu.wr(AD, 8'h10);
        cpu.prog(8'h00);
        mem[16] = mem[a];
        reset_n = 1'b0;
        @(negedge clk_i);
        reset_n = 1'b1;
        repeat (3) @(negedge clk_i);
        cpu.rd(CT, v);
        `CHK("busy after reset", 8'h02, v)
        wait_idle();
        rd_byte(16);
        test_done();
    end
    initial begin
        repeat (50000) @(posedge clk_i);
        n_errors++;
        test_done();
    end
endmodule
